/* pkg/msd_defs.svh */
// constants of the motor load stall detector
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH
`define MSD_ADR_CTRL        8'h00
`define MSD_ADR_THRS        8'h04
`define MSD_ADR_LOWLIM      8'h08
`define MSD_ADR_QUIETLIM    8'h0C
`define MSD_ADR_STEPINT     8'h10
`define MSD_ADR_RESULT      8'h14
`define MSD_ADR_IRQ_STAT    8'h18
`define MSD_ADR_IRQ_EN      8'h1C
`define MSD_ADR_IRQ_CLR     8'h20
`define MSD_CTRL_QUIET_BIT  0
`define MSD_RST_THRS        8'h00
`define MSD_RST_LOWLIM      20'h00000
`define MSD_RST_QUIETLIM    20'h00000
`define MSD_RST_CTRL        1'h1
`define MSD_PULSE_NS        400
`define MSD_CLK_NS          100
`define MSD_PULSE_CYC       ((`MSD_PULSE_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)
`endif

/* pkg/msd_pkg.sv */
// types of the motor load stall detector
package msd_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } msd_wb_req_s;
  typedef enum logic [1:0] {
    MSD_IDLE  = 2'b00,
    MSD_ARMED = 2'b01,
    MSD_PULSE = 2'b11,
    MSD_HELD  = 2'b10
  } msd_state_e;
endpackage : msd_pkg

/* core/msd_stall_detector.sv */
// stall detector with wishbone registers and interrupt
`include "msd_defs.svh"
module msd_stall_detector #(
  parameter int TW = 20
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        full_step_i,
  input  wire logic [8:0]  load_result_i,
  input  wire logic [TW-1:0] step_interval_i,
  output logic             fault_indicator_out_o,
  output logic             cycle_chopper_mode_o,
  output logic             irq_o
);
  localparam logic [2:0] PULSE_CYC = 3'(`MSD_PULSE_CYC);

  msd_pkg::msd_wb_req_s req;
  msd_pkg::msd_state_e  state_reg;
  msd_pkg::msd_state_e  state_next;
  logic          ack_reg;
  logic [31:0]   rdat_reg;
  logic          quiet_reg;
  logic [7:0]    thrs_reg;
  logic [TW-1:0] lowlim_reg;
  logic [TW-1:0] quietlim_reg;
  logic [8:0]    result_reg;
  logic [2:0]    cnt_reg;
  logic [1:0]    stat_reg;
  logic [1:0]    en_reg;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // bus decode
  wire acc    = req.cyc && req.stb && !ack_reg;
  wire wr     = acc && req.we;
  wire wr_ctl = wr && req.adr == `MSD_ADR_CTRL && req.sel[0];
  wire wr_thr = wr && req.adr == `MSD_ADR_THRS && req.sel[0];
  wire wr_low = wr && req.adr == `MSD_ADR_LOWLIM;
  wire wr_qui = wr && req.adr == `MSD_ADR_QUIETLIM;
  wire wr_en  = wr && req.adr == `MSD_ADR_IRQ_EN && req.sel[0];
  wire wr_clr = wr && req.adr == `MSD_ADR_IRQ_CLR && req.sel[0];

  // velocity window and mode
  wire too_fast   = step_interval_i <= quietlim_reg;
  wire slow_ok    = lowlim_reg >= step_interval_i;
  wire window_ok  = quiet_reg && slow_ok && !too_fast;
  wire [8:0] dbl  = {thrs_reg, 1'b0};
  wire below      = load_result_i < dbl;
  wire hit        = full_step_i && window_ok && below;
  wire pulse_end  = state_reg == msd_pkg::MSD_PULSE && cnt_reg == 3'h1;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      msd_pkg::MSD_IDLE:  if (window_ok) state_next = msd_pkg::MSD_ARMED;
      msd_pkg::MSD_ARMED: begin
        if (hit) state_next = msd_pkg::MSD_PULSE;
        else if (!window_ok) state_next = msd_pkg::MSD_IDLE;
      end
      msd_pkg::MSD_PULSE: if (pulse_end) state_next = msd_pkg::MSD_HELD;
      msd_pkg::MSD_HELD: begin
        if (full_step_i && !(window_ok && below)) state_next = msd_pkg::MSD_IDLE;
      end
      default: state_next = msd_pkg::MSD_IDLE;
    endcase
  end

  wire [TW-1:0] wmask = TW'({{8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}});
  wire [TW-1:0] wval  = req.dat[TW-1:0];

  wire [31:0] rd_mux =
    req.adr == `MSD_ADR_CTRL     ? {31'h0, quiet_reg} :
    req.adr == `MSD_ADR_THRS     ? {24'h0, thrs_reg} :
    req.adr == `MSD_ADR_LOWLIM   ? 32'(lowlim_reg) :
    req.adr == `MSD_ADR_QUIETLIM ? 32'(quietlim_reg) :
    req.adr == `MSD_ADR_STEPINT  ? 32'(step_interval_i) :
    req.adr == `MSD_ADR_RESULT   ? {23'h0, result_reg} :
    req.adr == `MSD_ADR_IRQ_STAT ? {30'h0, stat_reg} :
    req.adr == `MSD_ADR_IRQ_EN   ? {30'h0, en_reg} : 32'h0;

  // bit0 stall pulse, bit1 full-step update; set wins over clear
  wire [1:0] ev = {full_step_i, hit && state_reg == msd_pkg::MSD_ARMED};

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg    <= msd_pkg::MSD_IDLE;
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0;
      quiet_reg    <= `MSD_RST_CTRL;
      thrs_reg     <= `MSD_RST_THRS;
      lowlim_reg   <= TW'(`MSD_RST_LOWLIM);
      quietlim_reg <= TW'(`MSD_RST_QUIETLIM);
      result_reg   <= 9'h000;
      cnt_reg      <= 3'h0;
      stat_reg     <= 2'h0;
      en_reg       <= 2'h0;
    end else begin
      state_reg <= state_next;
      ack_reg   <= acc;
      if (acc) rdat_reg <= rd_mux;
      if (wr_ctl) quiet_reg <= req.dat[`MSD_CTRL_QUIET_BIT];
      if (wr_thr) thrs_reg <= req.dat[7:0];
      if (wr_low) lowlim_reg <= (lowlim_reg & ~wmask) | (wval & wmask);
      if (wr_qui) quietlim_reg <= (quietlim_reg & ~wmask) | (wval & wmask);
      if (wr_en) en_reg <= req.dat[1:0];
      if (full_step_i) result_reg <= load_result_i;
      if (state_next == msd_pkg::MSD_PULSE && state_reg != msd_pkg::MSD_PULSE)
        cnt_reg <= PULSE_CYC;
      else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      stat_reg <= (stat_reg & ~(wr_clr ? req.dat[1:0] : 2'h0)) | ev;
    end
  end

  assign wb_ack_o              = ack_reg;
  assign wb_dat_o              = rdat_reg;
  assign fault_indicator_out_o = state_reg == msd_pkg::MSD_PULSE;
  assign cycle_chopper_mode_o  = !quiet_reg || too_fast;
  assign irq_o                 = |(stat_reg & en_reg);
endmodule : msd_stall_detector

/* verif/msd_asserts.sv */
// checker of the stall detector ports
module msd_asserts (
  input wire logic       mclk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_ack_o, full_step_i,
  input wire logic [8:0] load_result_i,
  input wire logic       fault_indicator_out_o, cycle_chopper_mode_o, irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire f = fault_indicator_out_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack");
  a_pulse_step: assert property ($rose(f) |-> $past(full_step_i)) else $error("step");
  a_pulse_load: assert property ($rose(f) |-> $past(load_result_i) < 9'h1FE) else $error("ld");
  a_pulse_len: assert property ($rose(f) |-> f[*4] ##1 !f) else $error("width");
  a_pulse_window: assert property ($rose(f) |-> !$past(cycle_chopper_mode_o)) else $error("w");
  a_no_refire: assert property ($fell(f) |-> !f ##1 !f) else $error("refire");
  cover property ($rose(f));
  cover property ($rose(irq_o));
  cover property (cycle_chopper_mode_o && full_step_i);
endmodule : msd_asserts
bind msd_stall_detector msd_asserts u_asserts (.mclk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .full_step_i, .load_result_i, .fault_indicator_out_o, .cycle_chopper_mode_o, .irq_o);

/* verif/msd_motion_ctrl.sv */
// motion controller model: a full step every 8 cycles, stops on a stall pulse
module msd_motion_ctrl (
  input  wire logic mclk_i, reset_n_i, run_i, fault_i,
  output logic      full_step_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_reg;
  logic       stop_reg;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) {cnt_reg, stop_reg} <= 4'h0;
    else {cnt_reg, stop_reg} <= {cnt_reg + 3'h1, run_i && (stop_reg || fault_i)};
  end
  assign full_step_o = run_i && !stop_reg && cnt_reg == 3'h0;
endmodule : msd_motion_ctrl

/* verif/test_motor_load_stall_detector.sv */
// bench of the motor load stall detector
module test_motor_load_stall_detector;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, full_step_i, run;
  logic fault_indicator_out_o, cycle_chopper_mode_o, irq_o;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [8:0] load_result_i;
  logic [19:0] step_interval_i;
  int fails, checked, pulses;
  msd_stall_detector #(.TW(20)) DUT (.mclk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .full_step_i, .load_result_i,
    .step_interval_i, .fault_indicator_out_o, .cycle_chopper_mode_o, .irq_o);
  msd_motion_ctrl u_ctrl (.mclk_i, .reset_n_i, .run_i(run), .fault_i(fault_indicator_out_o),
    .full_step_o(full_step_i));
  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge fault_indicator_out_o) pulses++;
  task finish_test;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] seen, exp, input string nm);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    do @(posedge mclk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e, $sformatf("reg %h", a));
  endtask : rd
  task run_case(input logic [31:0] thr, input logic [19:0] iv, input logic [8:0] ld, int e);
    wb(1'h1, 8'h04, thr);
    {step_interval_i, load_result_i, run} <= {iv, ld, 1'h1};
    pulses = 0;
    repeat (48) @(posedge mclk_i);
    run <= 1'h0;
    chk(pulses, e, "pulses");
  endtask : run_case
  initial begin
    {reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, run, wb_adr_i, wb_dat_i} = '0;
    {wb_sel_i, load_result_i, step_interval_i} = {4'hF, 29'h0};
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h0);
    rd(8'h30, 32'h0);
    wb(1'h1, 8'h08, 32'h100);
    wb(1'h1, 8'h0C, 32'h10);
    wb(1'h1, 8'h1C, 32'h1);
    run_case(32'h40, 20'h50, 9'h080, 0);
    run_case(32'h41, 20'h50, 9'h080, 1);
    chk(cycle_chopper_mode_o, 32'h0, "chopper quiet");
    chk(irq_o, 32'h1, "irq");
    rd(8'h18, 32'h3);
    rd(8'h14, 32'h80);
    wb(1'h1, 8'h1C, 32'h0);
    chk(irq_o, 32'h0, "irq masked");
    wb(1'h1, 8'h20, 32'h3);
    rd(8'h18, 32'h0);
    run_case(32'h41, 20'h101, 9'h07F, 0);
    run_case(32'h41, 20'h10, 9'h07F, 0);
    chk(cycle_chopper_mode_o, 32'h1, "chopper");
    rd(8'h0C, 32'h10);
    rd(8'h08, 32'h100);
    rd(8'h10, 32'h10);
    wb(1'h1, 8'h00, 32'h0);
    run_case(32'h41, 20'h50, 9'h07F, 0);
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    finish_test;
  end
endmodule : test_motor_load_stall_detector
